// file: common/rss_pkg.sv
/*
 Shared constants for the reset source sequencer: register map,
 field positions, reset values, timing figures and state codes.
 Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package rss_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned PIN_MIN_WIDTH_NS = 400;
   localparam int unsigned PIN_MIN_CYC =
      (PIN_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DROP_MIN_WIDTH_US = 2;
   localparam int unsigned DROP_MIN_CYC =
      (DROP_MIN_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BG_STARTUP_US = 40;
   localparam int unsigned BG_STARTUP_CYC =
      (BG_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STARTUP_DELAY_DEF = 4096;

   // ==========================================================
   // Reset sources feeding the qualifiers
   localparam int unsigned SRC_N = 3;
   localparam int unsigned SRC_POR = 0;
   localparam int unsigned SRC_PIN = 1;
   localparam int unsigned SRC_DROP = 2;
   localparam int unsigned SRC_QUAL [SRC_N] =
      '{1, PIN_MIN_CYC, DROP_MIN_CYC};

   // ==========================================================
   // Register map (byte addresses)
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] OFF_CAUSE = 12'h000;
   localparam logic [11:0] OFF_REF_CTL = 12'h004;
   localparam logic [11:0] OFF_SEQ_STAT = 12'h008;

   // reset_cause_status fields
   localparam int unsigned WD_FLAG_BIT = 3;
   localparam int unsigned DROP_FLAG_BIT = 2;
   localparam int unsigned PIN_FLAG_BIT = 1;
   localparam int unsigned PWR_FLAG_BIT = 0;
   localparam logic [3:0] CAUSE_RESET = 4'h1;

   // Reference control fields
   localparam int unsigned CTL_CMP_BG_BIT = 0;
   localparam int unsigned CTL_ADC_EN_BIT = 1;
   localparam int unsigned CTL_DAC_EN_BIT = 2;
   localparam logic [2:0] CTL_RESET = 3'h0;

   // Sequencer status fields
   localparam int unsigned ST_BG_ON_BIT = 0;
   localparam int unsigned ST_DROP_EN_BIT = 1;
   localparam int unsigned ST_LEVEL_LSB = 2;
   localparam int unsigned ST_DROP_ACT_BIT = 5;
   localparam int unsigned ST_BG_READY_BIT = 6;

   // Fuse code that switches the supply drop detector off
   localparam logic [2:0] DROP_FUSE_OFF = 3'h7;

   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ST_HOLD  = 3'h1,
      ST_DELAY = 3'h2,
      ST_RUN   = 3'h4
   } rss_seq_e;

endpackage

// file: common/rss_src_if.sv
/*
 Carrier for one qualified reset source between its qualifier and
 the sequencer. Assumes both ends sit on the system clock.
*/
`timescale 1ns/1ps
interface rss_src_if;
   logic active;
   logic sync_level;
   modport filt (output active, output sync_level);
   modport seq (input active, input sync_level);
endinterface

// file: logic/rss_filter.sv
/*
 Synchroniser and width qualifier for one asynchronous reset source.
 Assumes an active-high raw level from outside the clock domain.
*/
`timescale 1ns/1ps
module rss_filter #(
   parameter int unsigned QUAL_CYC = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Raw source
   input wire logic i_raw,
   // Qualified source
   rss_src_if.filt src
);
   localparam int unsigned CW = $clog2(QUAL_CYC + 1);
   localparam logic [CW-1:0] QUAL_V = CW'(QUAL_CYC);

   if (QUAL_CYC < 1) begin : g_chk
      $error("rss_filter: QUAL_CYC must be at least 1");
   end

   logic s1_q;
   logic s2_q;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic act_q;
   logic act_d;

   // ==========================================================
   // Stable-width counter
   always_comb begin
      cnt_d = '0;
      if (s2_q) begin
         cnt_d = (cnt_q == QUAL_V) ? cnt_q : cnt_q + 1'b1;
      end
      act_d = (cnt_d == QUAL_V);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         cnt_q <= '0;
         act_q <= 1'b0;
      end else begin
         s1_q <= i_raw;
         s2_q <= s1_q;
         cnt_q <= cnt_d;
         act_q <= act_d;
      end
   end

   assign src.active = act_q;
   assign src.sync_level = s2_q;
endmodule

// file: logic/rss_top.sv
/*
 Reset source sequencer: combines power-on, reset pin, supply drop
 and watchdog sources, stretches the core reset by a start-up delay,
 records the reset cause and powers the bandgap reference.
 Assumes asynchronous detector and pin inputs, a watchdog that
 signals each expiry by toggling a level, and an APB master.

*/
`timescale 1ns/1ps
module rss_top
   import rss_pkg::*;
#(
   parameter int unsigned STARTUP_DELAY_CYC = STARTUP_DELAY_DEF
) (
   // Clock and block reset
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   // Supply detectors, pin and watchdog
   input wire logic I_SUPPLY_BELOW_POR,
   input wire logic I_RESET_PIN_N,
   input wire logic I_SUPPLY_DROP,
   input wire logic I_WDT_EXPIRE_TGL,
   input wire logic [2:0] I_DROP_LEVEL_FUSES,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // Reset and analog control
   output logic O_SYS_RESET_N,
   output logic O_BANDGAP_ON,
   output logic O_DROP_DET_EN,
   output logic [2:0] O_DROP_LEVEL
);
   localparam int unsigned DW = $clog2(STARTUP_DELAY_CYC + 1);
   localparam logic [DW-1:0] DELAY_LAST = DW'(STARTUP_DELAY_CYC - 1);
   localparam int unsigned BW = $clog2(BG_STARTUP_CYC + 1);
   localparam logic [BW-1:0] BG_DONE = BW'(BG_STARTUP_CYC);

   if (STARTUP_DELAY_CYC < 1) begin : g_chk
      $error("rss_top: STARTUP_DELAY_CYC must be at least 1");
   end

   function automatic logic reg_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] off
   );
      return addr == off;
   endfunction

   // ==========================================================
   // Source qualification
   logic [SRC_N-1:0] src_raw;
   logic [SRC_N-1:0] src_act;

   assign src_raw[SRC_POR] = I_SUPPLY_BELOW_POR;
   assign src_raw[SRC_PIN] = ~I_RESET_PIN_N;
   assign src_raw[SRC_DROP] = I_SUPPLY_DROP;

   for (genvar i = 0; i < SRC_N; i++) begin : g_src
      rss_src_if sif ();
      // Each source needs its own minimum width from SRC_QUAL before it counts
      rss_filter #(
         .QUAL_CYC(SRC_QUAL[i])
      ) u_filt (
         .i_clk(I_CLK_SYS),
         .i_rst_n(I_RESETN),
         .i_raw(src_raw[i]),
         .src(sif.filt)
      );
      assign src_act[i] = sif.active;
   end

   // ==========================================================
   // Fuse and watchdog synchronisers
   logic [2:0] fuse_s1_q;
   logic [2:0] fuse_q;
   logic wdt_s1_q;
   logic wdt_s2_q;
   logic wdt_s3_q;

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         fuse_s1_q <= DROP_FUSE_OFF;
         fuse_q <= DROP_FUSE_OFF;
         wdt_s1_q <= 1'b0;
         wdt_s2_q <= 1'b0;
         wdt_s3_q <= 1'b0;
      end else begin
         fuse_s1_q <= I_DROP_LEVEL_FUSES;
         fuse_q <= fuse_s1_q;
         wdt_s1_q <= I_WDT_EXPIRE_TGL;
         wdt_s2_q <= wdt_s1_q;
         wdt_s3_q <= wdt_s2_q;
      end
   end

   logic drop_en;
   logic por_act;
   logic pin_act;
   logic drop_act;
   logic wdt_pulse;
   logic any_src;

   assign drop_en = (fuse_q != DROP_FUSE_OFF);
   assign por_act = src_act[SRC_POR];
   assign pin_act = src_act[SRC_PIN];
   assign drop_act = src_act[SRC_DROP] & drop_en;
   // Expiry toggles arrive from the slow watchdog oscillator
   assign wdt_pulse = wdt_s2_q ^ wdt_s3_q;
   assign any_src = por_act | pin_act | drop_act | wdt_pulse;

   // ==========================================================
   // Start-up delay sequencer
   rss_seq_e st_q;
   rss_seq_e st_d;
   logic [DW-1:0] dly_q;
   logic [DW-1:0] dly_d;

   always_comb begin
      st_d = st_q;
      dly_d = dly_q;
      case (st_q)
         ST_HOLD: begin
            dly_d = '0;
            // Source released: begin the delay
            if (!any_src) begin
               st_d = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (any_src) begin
               st_d = ST_HOLD;
               dly_d = '0;
            end else if (dly_q == DELAY_LAST) begin
               st_d = ST_RUN;
            end else begin
               dly_d = dly_q + 1'b1;
            end
         end
         ST_RUN: begin
            dly_d = '0;
            if (any_src) begin
               st_d = ST_HOLD;
            end
         end
         default: begin
            st_d = ST_HOLD;
            dly_d = '0;
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         st_q <= ST_HOLD;
         dly_q <= '0;
      end else begin
         st_q <= st_d;
         dly_q <= dly_d;
      end
   end

   // Raw supply and pin gate the output with no clock involved
   assign O_SYS_RESET_N = (st_q == ST_RUN)
      & I_RESET_PIN_N
      & ~I_SUPPLY_BELOW_POR;

   // ==========================================================
   // APB access decode
   logic wr_en;
   logic rd_setup;
   logic hit_any;

   assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
   assign hit_any = reg_hit(I_PADDR, OFF_CAUSE)
      | reg_hit(I_PADDR, OFF_REF_CTL)
      | reg_hit(I_PADDR, OFF_SEQ_STAT);
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit_any;

   // ==========================================================
   // Reset cause flags (block reset only, not system reset)
   logic [3:0] cause_q;
   logic [3:0] cause_d;
   logic [3:0] cause_set;

   always_comb begin
      cause_set = '0;
      cause_set[WD_FLAG_BIT] = wdt_pulse;
      cause_set[DROP_FLAG_BIT] = drop_act;
      cause_set[PIN_FLAG_BIT] = pin_act;
      cause_set[PWR_FLAG_BIT] = por_act;
      cause_d = cause_q;
      // Writing zero clears a flag, writing one keeps it
      if (wr_en && reg_hit(I_PADDR, OFF_CAUSE)) begin
         cause_d = cause_q & I_PWDATA[3:0];
      end
      // A new event beats a software clear in the same cycle
      cause_d = cause_d | cause_set;
      // Power-on clears the other flags, never its own
      if (por_act) begin
         cause_d[WD_FLAG_BIT] = 1'b0;
         cause_d[DROP_FLAG_BIT] = 1'b0;
         cause_d[PIN_FLAG_BIT] = 1'b0;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         cause_q <= CAUSE_RESET;
      end else begin
         cause_q <= cause_d;
      end
   end

   // ==========================================================
   // Reference control and bandgap power
   logic [2:0] ctl_q;
   logic [2:0] ctl_d;
   logic bg_on_q;
   logic bg_on_d;
   logic [BW-1:0] bg_cnt_q;
   logic [BW-1:0] bg_cnt_d;

   always_comb begin
      ctl_d = ctl_q;
      if (wr_en && reg_hit(I_PADDR, OFF_REF_CTL)) begin
         ctl_d = I_PWDATA[2:0];
      end
      bg_on_d = drop_en
         | ctl_q[CTL_CMP_BG_BIT]
         | ctl_q[CTL_ADC_EN_BIT]
         | ctl_q[CTL_DAC_EN_BIT];
      // Start-up timer tells software when the reference is usable
      bg_cnt_d = '0;
      if (bg_on_q) begin
         bg_cnt_d = (bg_cnt_q == BG_DONE) ? bg_cnt_q
            : bg_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         ctl_q <= CTL_RESET;
         bg_on_q <= 1'b0;
         bg_cnt_q <= '0;
      end else begin
         ctl_q <= ctl_d;
         bg_on_q <= bg_on_d;
         bg_cnt_q <= bg_cnt_d;
      end
   end

   assign O_BANDGAP_ON = bg_on_q;
   assign O_DROP_DET_EN = drop_en;
   assign O_DROP_LEVEL = fuse_q;

   // ==========================================================
   // Read data, captured in the setup cycle
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [6:0] seq_stat;

   always_comb begin
      seq_stat = '0;
      seq_stat[ST_BG_ON_BIT] = bg_on_q;
      seq_stat[ST_DROP_EN_BIT] = drop_en;
      seq_stat[ST_LEVEL_LSB +: 3] = fuse_q;
      seq_stat[ST_DROP_ACT_BIT] = drop_act;
      seq_stat[ST_BG_READY_BIT] = (bg_cnt_q == BG_DONE);
      rdata_d = rdata_q;
      if (rd_setup) begin
         rdata_d = '0;
         if (reg_hit(I_PADDR, OFF_CAUSE)) begin
            rdata_d[3:0] = cause_q;
         end else if (reg_hit(I_PADDR, OFF_REF_CTL)) begin
            rdata_d[2:0] = ctl_q;
         end else if (reg_hit(I_PADDR, OFF_SEQ_STAT)) begin
            rdata_d[6:0] = seq_stat;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign O_PRDATA = rdata_q;
endmodule

// file: test/rss_src_model.sv
/*
 Far-side model: supply detectors, reset pin, fuses and watchdog.
 Assumes the bench calls its tasks to raise and release sources.
*/
`timescale 1ns/1ps
module rss_src_model (
   // Clock
   input wire logic i_clk,
   // Source levels
   output logic o_por,
   output logic o_pin_n,
   output logic o_drop,
   output logic o_wdt_tgl,
   output logic [2:0] o_fuses
);
   // ==========================================
   // Watchdog oscillator, about 128 kHz
   logic osc_slow = 1'b0;
   always #3906.25 osc_slow = ~osc_slow;
   initial begin
      o_por = 1'b0;
      o_pin_n = 1'b1;
      o_drop = 1'b0;
      o_wdt_tgl = 1'b0;
      o_fuses = 3'h7;
   end
   // Holds one source active for n cycles
   task automatic pulse(input int src, input int n);
      @(posedge i_clk);
      case (src)
         0: o_por <= 1'b1;
         1: o_pin_n <= 1'b0;
         default: o_drop <= 1'b1;
      endcase
      repeat (n) @(posedge i_clk);
      o_por <= 1'b0;
      o_pin_n <= 1'b1;
      o_drop <= 1'b0;
   endtask
   // One expiry, launched from the slow domain
   task automatic expire();
      @(posedge osc_slow);
      o_wdt_tgl <= ~o_wdt_tgl;
   endtask
   task automatic set_fuses(input logic [2:0] f);
      @(posedge i_clk);
      o_fuses <= f;
      repeat (6) @(posedge i_clk);
   endtask
endmodule

// file: test/rss_top_sva.sv
/*
 Port checker for the reset source sequencer.
 Assumes binding onto rss_top with its delay parameter passed on.
*/
`timescale 1ns/1ps
module rss_top_sva
   import rss_pkg::*;
#(
   parameter int unsigned STARTUP_DELAY_CYC = STARTUP_DELAY_DEF
) (
   // Clock, reset and sources
   input wire logic I_CLK_SYS,
   input wire logic I_RESETN,
   input wire logic I_SUPPLY_BELOW_POR,
   input wire logic I_RESET_PIN_N,
   input wire logic I_SUPPLY_DROP,
   input wire logic I_WDT_EXPIRE_TGL,
   input wire logic [2:0] I_DROP_LEVEL_FUSES,
   // APB
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   // Outputs
   input wire logic O_SYS_RESET_N,
   input wire logic O_BANDGAP_ON,
   input wire logic O_DROP_DET_EN,
   input wire logic [2:0] O_DROP_LEVEL
);
   // ==========================================
   // Run lengths of reset low and drop high
   logic [15:0] low_cnt_q, low_cnt_d, drop_cnt_q, drop_cnt_d;
   always_comb begin
      low_cnt_d = O_SYS_RESET_N ? 16'h0 : low_cnt_q + 16'h1;
      drop_cnt_d = I_SUPPLY_DROP ? drop_cnt_q + 16'h1 : 16'h0;
   end
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESETN) begin
         low_cnt_q <= 16'h0;
         drop_cnt_q <= 16'h0;
      end else begin
         low_cnt_q <= low_cnt_d;
         drop_cnt_q <= drop_cnt_d;
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESETN);
   chk_pin_forces_reset: assert property (
      !I_RESET_PIN_N |-> !O_SYS_RESET_N) else $error("pin low, no reset");
   chk_por_forces_reset: assert property (
      I_SUPPLY_BELOW_POR |-> !O_SYS_RESET_N) else $error("por, no reset");
   chk_release_after_delay: assert property (
      $rose(O_SYS_RESET_N) |-> low_cnt_q >= STARTUP_DELAY_CYC)
      else $error("reset released before delay");
   chk_drop_gives_reset: assert property (
      O_DROP_DET_EN && drop_cnt_q == DROP_MIN_CYC + 6 |-> !O_SYS_RESET_N)
      else $error("long drop, no reset");
   chk_wdt_gives_reset: assert property (
      $changed(I_WDT_EXPIRE_TGL) |-> ##[1:8] !O_SYS_RESET_N)
      else $error("watchdog expiry, no reset");
   chk_fuse_disables: assert property (
      O_DROP_DET_EN == (O_DROP_LEVEL != DROP_FUSE_OFF))
      else $error("detector enable wrong for fuse code");
   chk_fuse_follows: assert property (
      $changed(I_DROP_LEVEL_FUSES) |->
      ##[1:4] O_DROP_LEVEL == I_DROP_LEVEL_FUSES)
      else $error("level does not follow fuses");
   chk_bg_for_det: assert property (
      O_DROP_DET_EN |-> ##[0:2] O_BANDGAP_ON)
      else $error("detector on, reference off");
   chk_unmapped_err: assert property (
      I_PSEL && I_PENABLE && I_PADDR > OFF_SEQ_STAT |-> O_PSLVERR)
      else $error("unmapped access without error");
endmodule
bind rss_top rss_top_sva #(
   .STARTUP_DELAY_CYC(STARTUP_DELAY_CYC)
) u_rss_top_sva (
   .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN),
   .I_SUPPLY_BELOW_POR(I_SUPPLY_BELOW_POR), .I_RESET_PIN_N(I_RESET_PIN_N),
   .I_SUPPLY_DROP(I_SUPPLY_DROP), .I_WDT_EXPIRE_TGL(I_WDT_EXPIRE_TGL),
   .I_DROP_LEVEL_FUSES(I_DROP_LEVEL_FUSES), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PREADY(O_PREADY),
   .O_PSLVERR(O_PSLVERR), .O_SYS_RESET_N(O_SYS_RESET_N),
   .O_BANDGAP_ON(O_BANDGAP_ON), .O_DROP_DET_EN(O_DROP_DET_EN),
   .O_DROP_LEVEL(O_DROP_LEVEL));

// file: test/rss_top_bench.sv
/*
 Self-checking bench for the reset source sequencer.
 Assumes the source model drives every detector input.
*/
`timescale 1ns/1ps
module rss_top_bench;
   import rss_pkg::*;
   localparam int unsigned DLY = 8;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, sys_rst_n, bg_on, det_en;
   logic por, pin_n, drop, wdt_tgl;
   logic [2:0] fuses, level;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   rss_top #(.STARTUP_DELAY_CYC(DLY)) u_rss_top (
      .I_CLK_SYS(clk), .I_RESETN(resetn), .I_SUPPLY_BELOW_POR(por),
      .I_RESET_PIN_N(pin_n), .I_SUPPLY_DROP(drop),
      .I_WDT_EXPIRE_TGL(wdt_tgl), .I_DROP_LEVEL_FUSES(fuses),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .O_SYS_RESET_N(sys_rst_n),
      .O_BANDGAP_ON(bg_on), .O_DROP_DET_EN(det_en), .O_DROP_LEVEL(level));
   rss_src_model u_rss_src_model (
      .i_clk(clk), .o_por(por), .o_pin_n(pin_n), .o_drop(drop),
      .o_wdt_tgl(wdt_tgl), .o_fuses(fuses));
   // ==========================================
   // Shared tasks
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      repeat (2) @(posedge clk);
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp);
   endtask
   // Cycles until the system reset lets go, then range test
   task automatic run_in(input int lo, input int hi);
      int n;
      n = 0;
      while (sys_rst_n !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_init();
      logic [31:0] r;
      logic e;
      run_in(DLY, DLY + 8);
      rd_chk(OFF_CAUSE, 32'h1);
      rd_chk(OFF_REF_CTL, 32'h0);
      rd_chk(OFF_SEQ_STAT, 32'h1c);
      apb(1'b0, 12'h00c, 32'h0, r, e);
      check({r[30:0], e}, 32'h1);
      wr(OFF_CAUSE, 32'h0);
      rd_chk(OFF_CAUSE, 32'h0);
      $display("t_init done");
   endtask
   task automatic t_pin();
      u_rss_src_model.pulse(1, 60);
      run_in(DLY, DLY + 8);
      rd_chk(OFF_CAUSE, 32'h2);
      wr(OFF_CAUSE, 32'hf);
      rd_chk(OFF_CAUSE, 32'h2);
      $display("t_pin done");
   endtask
   task automatic t_wdt();
      int n;
      n = 0;
      u_rss_src_model.expire();
      while (sys_rst_n === 1'b1 && n < 10) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, n < 10}, 32'h1);
      run_in(DLY, DLY + 4);
      rd_chk(OFF_CAUSE, 32'ha);
      $display("t_wdt done");
   endtask
   task automatic t_drop();
      u_rss_src_model.set_fuses(3'h2);
      check({27'h0, bg_on, det_en, level}, 32'h1a);
      rd_chk(OFF_SEQ_STAT, 32'h0b);
      u_rss_src_model.pulse(2, 100);
      repeat (10) @(posedge clk);
      check({31'h0, sys_rst_n}, 32'h1);
      u_rss_src_model.pulse(2, DROP_MIN_CYC + 50);
      run_in(DLY, DLY + 8);
      rd_chk(OFF_CAUSE, 32'he);
      u_rss_src_model.pulse(0, 20);
      run_in(DLY, DLY + 8);
      rd_chk(OFF_CAUSE, 32'h1);
      $display("t_drop done");
   endtask
   task automatic t_bg();
      u_rss_src_model.set_fuses(3'h7);
      check({27'h0, bg_on, det_en, level}, 32'h7);
      u_rss_src_model.pulse(2, DROP_MIN_CYC + 50);
      check({31'h0, sys_rst_n}, 32'h1);
      rd_chk(OFF_CAUSE, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr(OFF_REF_CTL, 32'h1 << i);
         rd_chk(OFF_SEQ_STAT, 32'h1d);
      end
      repeat (BG_STARTUP_CYC) @(posedge clk);
      rd_chk(OFF_SEQ_STAT, 32'h5d);
      check({27'h0, bg_on, det_en, level}, 32'h17);
      wr(OFF_REF_CTL, 32'h0);
      rd_chk(OFF_SEQ_STAT, 32'h1c);
      check({27'h0, bg_on, det_en, level}, 32'h7);
      $display("t_bg done");
   endtask
   // ==========================================
   // Main sequence and hang limit
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t_init();
      t_pin();
      t_wdt();
      t_drop();
      t_bg();
      report_and_stop();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
endmodule
